// ---- iat_map.vh ----
/*
 * Register map, field layout, reset values and widths for the input
 * alarm threshold register bank.
 * Assumes byte addresses on an APB bus with 32-bit data, one aligned
 * word per register.
 */
`ifndef IAT_MAP_VH
`define IAT_MAP_VH

// ----------------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------------
`define IAT_ADDR_W 8
`define IAT_ADDR_UPPER 8'h24
`define IAT_ADDR_LOWER 8'h28
`define IAT_ADDR_STATUS 8'h2c

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define IAT_RST_HYST_BYTE 8'h00
`define IAT_RST_UPPER_FIELD 16'hffff
`define IAT_RST_LOWER_FIELD 16'h0000

// ----------------------------------------------------------------------
// upper- and lower-threshold register fields
// ----------------------------------------------------------------------
`define IAT_HYST_BYTE_HI 31
`define IAT_HYST_BYTE_LO 24
`define IAT_HYST_VAL_HI 7
`define IAT_HYST_VAL_LO 4
`define IAT_UPPER_RSVD_HI 23
`define IAT_UPPER_RSVD_LO 16
`define IAT_FIELD_HI 15
`define IAT_FIELD_LO 0
`define IAT_LIMIT_HI 15
`define IAT_LIMIT_LO 2
`define IAT_LOWER_RSVD_HI 31
`define IAT_LOWER_RSVD_LO 16

// ----------------------------------------------------------------------
// status register fields
// ----------------------------------------------------------------------
`define IAT_ST_SUMMARY 0
`define IAT_ST_TRIP_HIGH 4
`define IAT_ST_TRIP_LOW 5
`define IAT_ST_ACT_HIGH 10
`define IAT_ST_ACT_LOW 11

// ----------------------------------------------------------------------
// byte lanes of the write strobe and of the 16-bit threshold fields
// ----------------------------------------------------------------------
`define IAT_LANE0 0
`define IAT_LANE1 1
`define IAT_LANE3 3
`define IAT_LANE0_HI 7
`define IAT_LANE0_LO 0
`define IAT_LANE1_HI 15
`define IAT_LANE1_LO 8

// ----------------------------------------------------------------------
// widths and constants
// ----------------------------------------------------------------------
`define IAT_RESULT_W 14
`define IAT_HYST_W 4
`define IAT_ZERO8 8'h00
`define IAT_ZERO16 16'h0000
`define IAT_ZERO32 32'h00000000
`define IAT_LIMIT_MAX 14'h3fff
`define IAT_LIMIT_MIN 14'h0000

`endif

// ---- iat_window_cmp.v ----
/*
 * Window comparator with hysteresis for the input alarm: keeps one
 * active flag for results above the upper limit and one for results
 * below the lower limit.
 * Assumes results arrive with a one-cycle valid strobe on pclk.
 */
`include "iat_map.vh"
`default_nettype none

module iat_window_cmp (
   input wire pclk,
   input wire presetn,
   input wire sample_valid,
   input wire [`IAT_RESULT_W-1:0] sample,
   input wire [`IAT_RESULT_W-1:0] upper_limit,
   input wire [`IAT_RESULT_W-1:0] lower_limit,
   input wire [`IAT_HYST_W-1:0] hyst,
   output reg active_high,
   output reg active_low
);

   // ----------------------------------------------------------------------
   // saturating arithmetic for the release points
   // ----------------------------------------------------------------------
   function [`IAT_RESULT_W-1:0] iat_sat_sub;
      input [`IAT_RESULT_W-1:0] a;
      input [`IAT_HYST_W-1:0] b;
      reg [`IAT_RESULT_W:0] t;
      begin
         t = {1'b0, a} - {{(`IAT_RESULT_W+1-`IAT_HYST_W){1'b0}}, b};
         if (t[`IAT_RESULT_W]) begin
            iat_sat_sub = `IAT_LIMIT_MIN;
         end else begin
            iat_sat_sub = t[`IAT_RESULT_W-1:0];
         end
      end
   endfunction

   function [`IAT_RESULT_W-1:0] iat_sat_add;
      input [`IAT_RESULT_W-1:0] a;
      input [`IAT_HYST_W-1:0] b;
      reg [`IAT_RESULT_W:0] t;
      begin
         t = {1'b0, a} + {{(`IAT_RESULT_W+1-`IAT_HYST_W){1'b0}}, b};
         if (t[`IAT_RESULT_W]) begin
            iat_sat_add = `IAT_LIMIT_MAX;
         end else begin
            iat_sat_add = t[`IAT_RESULT_W-1:0];
         end
      end
   endfunction

   wire [`IAT_RESULT_W-1:0] high_release;
   wire [`IAT_RESULT_W-1:0] low_release;

   // release points sit one hysteresis step inside each limit
   assign high_release = iat_sat_sub(upper_limit, hyst);
   assign low_release = iat_sat_add(lower_limit, hyst);

   // ----------------------------------------------------------------------
   // active flags: set past a limit, cleared once back at or past the release
   // ----------------------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         active_high <= 1'b0;
         active_low <= 1'b0;
      end else if (sample_valid) begin
         if (sample > upper_limit) begin
            active_high <= 1'b1;
         end else if (sample <= high_release) begin
            active_high <= 1'b0;
         end
         if (sample < lower_limit) begin
            active_low <= 1'b1;
         end else if (sample >= low_release) begin
            active_low <= 1'b0;
         end
      end
   end

endmodule // iat_window_cmp

`default_nettype wire

// ---- iat_regs.v ----
/*
 * Input alarm threshold register bank: hysteresis, upper and lower
 * thresholds as an APB slave, plus the window comparison of conversion
 * results and the alarm flags that come from it.
 * Assumes an APB master on pclk, byte strobes on pstrb, and conversion
 * results that come with a one-cycle valid strobe on the same clock.
 */
//
// Contract
// - hysteresis is upper nibble of top byte
// - high limit uses upper field bits 15:2
// - low limit uses lower field bits 15:2
// - upper register bits 23:16 read zero
// - lower register bits 31:16 read zero
// - upper register bytes little-endian, four addresses; the code decodes only the word address, and pstrb selects the bytes
// - lower register bytes little-endian, four addresses; the code decodes only the word address, and pstrb selects the bytes
// - summary bit ORs all tripped alarm flags
`include "iat_map.vh"
`default_nettype none

module iat_regs (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [`IAT_ADDR_W-1:0] paddr,
   input wire [31:0] pwdata,
   input wire [3:0] pstrb,
   output reg pready,
   output reg [31:0] prdata,
   output reg pslverr,
   input wire conv_valid,
   input wire [`IAT_RESULT_W-1:0] conv_result,
   output wire alarm_high_active,
   output wire alarm_low_active,
   output reg alarm_high_tripped,
   output reg alarm_low_tripped,
   output reg overall_alarm_summary
);

   // ----------------------------------------------------------------------
   // storage
   // ----------------------------------------------------------------------
   reg [7:0] input_alarm_hysteresis;
   reg [15:0] input_alarm_upper_limit;
   reg [15:0] input_alarm_lower_limit;

   reg next_trip_high;
   reg next_trip_low;
   reg [31:0] next_rdata;
   reg next_err;

   wire access_done;
   wire wr_done;
   wire hit_upper;
   wire hit_lower;
   wire hit_status;
   wire mapped;
   wire [`IAT_HYST_W-1:0] hyst_value;
   wire [`IAT_RESULT_W-1:0] upper_cmp;
   wire [`IAT_RESULT_W-1:0] lower_cmp;
   wire trip_high_clear;
   wire trip_low_clear;
   wire [31:0] upper_word;
   wire [31:0] lower_word;
   reg [31:0] status_word;

   // ----------------------------------------------------------------------
   // helper functions
   // ----------------------------------------------------------------------
   // one aligned word per register: a hit needs the whole byte address,
   // so a byte address inside a word never aliases onto the word itself
   function iat_hit;
      input [`IAT_ADDR_W-1:0] addr;
      input [`IAT_ADDR_W-1:0] base;
      begin
         iat_hit = (addr == base);
      end
   endfunction

   // byte-lane merge of a 16-bit threshold field: a lane whose strobe is
   // set takes the bus byte, the other lane keeps what it held, so the
   // host may program a field one byte lane at a time at the word address
   function [15:0] iat_merge16;
      input [15:0] old;
      input [15:0] wdata;
      input [1:0] strb;
      begin
         iat_merge16 = old;
         if (strb[`IAT_LANE0]) begin
            iat_merge16[`IAT_LANE0_HI:`IAT_LANE0_LO] =
               wdata[`IAT_LANE0_HI:`IAT_LANE0_LO];
         end
         if (strb[`IAT_LANE1]) begin
            iat_merge16[`IAT_LANE1_HI:`IAT_LANE1_LO] =
               wdata[`IAT_LANE1_HI:`IAT_LANE1_LO];
         end
      end
   endfunction

   // ----------------------------------------------------------------------
   // apb handshake
   // ----------------------------------------------------------------------
   // the answer comes one wait state after the access phase opens, so the
   // read data can be taken from a flip-flop
   assign access_done = psel & penable & pready;
   assign wr_done = access_done & pwrite;

   // address decode, one aligned word per register
   assign hit_upper = iat_hit(paddr, `IAT_ADDR_UPPER);
   assign hit_lower = iat_hit(paddr, `IAT_ADDR_LOWER);
   assign hit_status = iat_hit(paddr, `IAT_ADDR_STATUS);
   assign mapped = hit_upper | hit_lower | hit_status;

   // pready rises in the second access cycle and drops right after
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
      end else begin
         pready <= psel & penable & ~pready;
      end
   end

   // ----------------------------------------------------------------------
   // read words with reserved bits forced to zero
   // ----------------------------------------------------------------------
   assign upper_word = {input_alarm_hysteresis,
                        `IAT_ZERO8,
                        input_alarm_upper_limit};
   assign lower_word = {`IAT_ZERO16,
                        input_alarm_lower_limit};
   // status word built bit by bit; every bit not named here reads zero,
   // and the flags are read as they stand, not through a capture stage
   always @* begin
      status_word = `IAT_ZERO32;
      status_word[`IAT_ST_SUMMARY] = overall_alarm_summary;
      status_word[`IAT_ST_TRIP_HIGH] = alarm_high_tripped;
      status_word[`IAT_ST_TRIP_LOW] = alarm_low_tripped;
      status_word[`IAT_ST_ACT_HIGH] = alarm_high_active;
      status_word[`IAT_ST_ACT_LOW] = alarm_low_active;
   end

   // read mux and error answer for unmapped addresses
   always @* begin
      next_rdata = `IAT_ZERO32;
      next_err = 1'b0;
      if (psel & penable & ~pready) begin
         if (hit_upper) begin
            next_rdata = pwrite ? `IAT_ZERO32 : upper_word;
         end else if (hit_lower) begin
            next_rdata = pwrite ? `IAT_ZERO32 : lower_word;
         end else if (hit_status) begin
            next_rdata = pwrite ? `IAT_ZERO32 : status_word;
         end
         next_err = ~mapped;
      end
   end

   // read data and error stand in the cycle that pready is high
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= `IAT_ZERO32;
         pslverr <= 1'b0;
      end else begin
         prdata <= next_rdata;
         pslverr <= next_err;
      end
   end

   // ----------------------------------------------------------------------
   // upper-threshold register, one byte lane at a time
   // ----------------------------------------------------------------------
   // lane 0 is the lowest byte address, lane 3 the highest; lane 2 is the
   // reserved byte and takes no write
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         input_alarm_hysteresis <= `IAT_RST_HYST_BYTE;
         input_alarm_upper_limit <= `IAT_RST_UPPER_FIELD;
      end else if (wr_done & hit_upper) begin
         input_alarm_upper_limit <= iat_merge16(input_alarm_upper_limit,
            pwdata[`IAT_FIELD_HI:`IAT_FIELD_LO],
            pstrb[`IAT_LANE1:`IAT_LANE0]);
         if (pstrb[`IAT_LANE3]) begin
            input_alarm_hysteresis <=
               pwdata[`IAT_HYST_BYTE_HI:`IAT_HYST_BYTE_LO];
         end
      end
   end

   // ----------------------------------------------------------------------
   // lower-threshold register, one byte lane at a time
   // ----------------------------------------------------------------------
   // lanes 2 and 3 are reserved and take no write
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         input_alarm_lower_limit <= `IAT_RST_LOWER_FIELD;
      end else if (wr_done & hit_lower) begin
         input_alarm_lower_limit <= iat_merge16(input_alarm_lower_limit,
            pwdata[`IAT_FIELD_HI:`IAT_FIELD_LO],
            pstrb[`IAT_LANE1:`IAT_LANE0]);
      end
   end

   // ----------------------------------------------------------------------
   // comparison operands
   // ----------------------------------------------------------------------
   // the low nibble of the hysteresis byte and the two low bits of each
   // threshold are left out, so stray ones written there have no effect
   assign hyst_value =
      input_alarm_hysteresis[`IAT_HYST_VAL_HI:`IAT_HYST_VAL_LO];
   assign upper_cmp =
      input_alarm_upper_limit[`IAT_LIMIT_HI:`IAT_LIMIT_LO];
   assign lower_cmp =
      input_alarm_lower_limit[`IAT_LIMIT_HI:`IAT_LIMIT_LO];

   // window comparator with hysteresis
   iat_window_cmp u_cmp (
      .pclk(pclk),
      .presetn(presetn),
      .sample_valid(conv_valid),
      .sample(conv_result),
      .upper_limit(upper_cmp),
      .lower_limit(lower_cmp),
      .hyst(hyst_value),
      .active_high(alarm_high_active),
      .active_low(alarm_low_active)
   );

   // ----------------------------------------------------------------------
   // tripped flags and summary
   // ----------------------------------------------------------------------
   // software clears a tripped flag by writing one to its status bit
   assign trip_high_clear = wr_done & hit_status & pstrb[`IAT_LANE0] &
                            pwdata[`IAT_ST_TRIP_HIGH];
   assign trip_low_clear = wr_done & hit_status & pstrb[`IAT_LANE0] &
                           pwdata[`IAT_ST_TRIP_LOW];

   // a live alarm sets the flag and wins over a clear in the same cycle
   always @* begin
      next_trip_high = alarm_high_tripped;
      next_trip_low = alarm_low_tripped;
      if (trip_high_clear) begin
         next_trip_high = 1'b0;
      end
      if (trip_low_clear) begin
         next_trip_low = 1'b0;
      end
      if (alarm_high_active) begin
         next_trip_high = 1'b1;
      end
      if (alarm_low_active) begin
         next_trip_low = 1'b1;
      end
   end

   // summary follows the tripped flags in the same edge
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         alarm_high_tripped <= 1'b0;
         alarm_low_tripped <= 1'b0;
         overall_alarm_summary <= 1'b0;
      end else begin
         alarm_high_tripped <= next_trip_high;
         alarm_low_tripped <= next_trip_low;
         overall_alarm_summary <= next_trip_high | next_trip_low;
      end
   end

endmodule // iat_regs

`default_nettype wire

// ---- iat_regs_sva.sv ----
/* checker for the input alarm threshold registers, seen at its ports.
   assumes one clock pclk and the asynchronous low reset presetn. */
`default_nettype none
module iat_regs_sva (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic pready,
   input wire logic [31:0] prdata,
   input wire logic pslverr,
   input wire logic conv_valid,
   input wire logic [13:0] conv_result,
   input wire logic alarm_high_active,
   input wire logic alarm_low_active,
   input wire logic alarm_high_tripped,
   input wire logic alarm_low_tripped,
   input wire logic overall_alarm_summary
);
   timeunit 1ns;
   timeprecision 1ns;
   // ----------------------------------------------------------------
   // bus and alarm properties
   // ----------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // setup cycle followed by the first access cycle
   sequence s_access;
      psel && !penable ##1 psel && penable;
   endsequence
   // completed write of the high clear bit while the high alarm is idle
   sequence s_clr_high;
      psel && penable && pready && pwrite && paddr == 8'h2c && pstrb[0]
         && pwdata[4] && !alarm_high_active;
   endsequence
   AST_ONE_WAIT: assert property (s_access |=> pready)
      else $error("ready not one cycle into access");
   AST_READY_PULSE: assert property (pready |=> !pready)
      else $error("ready held longer than one cycle");
   AST_UPPER_RSVD: assert property (pready && !pwrite && paddr == 8'h24
      |-> prdata[23:16] == 8'h00)
      else $error("upper reserved byte not zero");
   AST_LOWER_RSVD: assert property (pready && !pwrite && paddr == 8'h28
      |-> prdata[31:16] == 16'h0000)
      else $error("lower reserved half not zero");
   AST_UNMAPPED: assert property (pready
      && !(paddr inside {8'h24, 8'h28, 8'h2c}) |-> pslverr)
      else $error("unmapped access without error");
   AST_SUMMARY: assert property (overall_alarm_summary
      == (alarm_high_tripped || alarm_low_tripped))
      else $error("summary differs from tripped flags");
   AST_TRIP_HIGH: assert property ($rose(alarm_high_active)
      |=> alarm_high_tripped)
      else $error("high trip missed");
   AST_TRIP_LOW: assert property ($rose(alarm_low_active)
      |=> alarm_low_tripped)
      else $error("low trip missed");
   AST_HIGH_STICKY: assert property (alarm_high_tripped
      && !(pready && pwrite && paddr == 8'h2c && pstrb[0] && pwdata[4])
      |=> alarm_high_tripped)
      else $error("high trip lost without clear");
   AST_HIGH_CLEAR: assert property (s_clr_high |=> !alarm_high_tripped)
      else $error("high trip not cleared by write");
endmodule // iat_regs_sva
bind iat_regs iat_regs_sva iat_regs_sva_inst (.pclk, .presetn, .psel,
   .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready, .prdata, .pslverr,
   .conv_valid, .conv_result, .alarm_high_active, .alarm_low_active,
   .alarm_high_tripped, .alarm_low_tripped, .overall_alarm_summary);
`default_nettype wire

// ---- iat_conv_src.sv ----
/* model of the converter that delivers results to the alarm logic.
   assumes the bench raises req for one cycle per result. */
`default_nettype none
module iat_conv_src (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic req,
   input wire logic [13:0] req_value,
   output var logic conv_valid,
   output var logic [13:0] conv_result
);
   timeunit 1ns;
   timeprecision 1ns;
   // one-cycle strobe; idle data toggles so stale values never match
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         conv_valid <= 1'b0;
         conv_result <= 14'h0000;
      end else begin
         conv_valid <= req;
         conv_result <= req ? req_value : ~conv_result;
      end
   end
endmodule // iat_conv_src
`default_nettype wire

// ---- input_alarm_threshold_regs_test.sv ----
/* self-checking bench for the input alarm threshold registers.
   assumes the design files and the converter model are compiled first. */
`default_nettype none
module input_alarm_threshold_regs_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic pclk, presetn, psel, penable, pwrite, req, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rdata;
   logic [3:0] pstrb;
   logic [13:0] req_value, conv_result;
   logic conv_valid, rerr, a_h, a_l, t_h, t_l, summ;
   int n_mismatch = 0;
   int comparisons = 0;
   int cyc = 0;
   iat_regs iat_regs_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .conv_valid(conv_valid), .conv_result(conv_result),
      .alarm_high_active(a_h), .alarm_low_active(a_l),
      .alarm_high_tripped(t_h), .alarm_low_tripped(t_l),
      .overall_alarm_summary(summ));
   iat_conv_src iat_conv_src_inst (.pclk(pclk), .presetn(presetn),
      .req(req), .req_value(req_value), .conv_valid(conv_valid),
      .conv_result(conv_result));
   // ----------------------------------------------------------------
   // clock, watchdog and tasks
   // ----------------------------------------------------------------
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   // cut a hang short well past the expected run length
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 3000) begin
         n_mismatch++;
         stop_test;
      end
   end
   task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   // one apb transfer; waits for pready, then releases the request
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, input logic [3:0] s);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rdata = prdata;
      rerr = pslverr;
      chk("pready", 32'h1, {31'h0, pready});
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h00000000, 4'h0);
      chk("prdata", e, rdata);
   endtask
   // one result from the converter, then alarm flags are compared
   task automatic conv(input logic [13:0] v, input logic [4:0] e);
      @(posedge pclk);
      req <= 1'b1;
      req_value <= v;
      @(posedge pclk);
      req <= 1'b0;
      repeat (3) @(posedge pclk);
      #1;
      chk("flags", {27'h0, e}, {27'h0, a_h, a_l, t_h, t_l, summ});
   endtask
   task stop_test;
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // ----------------------------------------------------------------
   // test sequence
   // ----------------------------------------------------------------
   initial begin
      {presetn, psel, penable, pwrite, req} = 5'h00;
      paddr = 8'h00;
      pwdata = 32'h00000000;
      pstrb = 4'h0;
      req_value = 14'h0000;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      rd(8'h24, 32'h0000ffff);
      rd(8'h28, 32'h00000000);
      rd(8'h2c, 32'h00000000);
      $display("test reset values done");
      apb(1'b1, 8'h24, 32'h50ee1234, 4'hf);
      rd(8'h24, 32'h50001234);
      apb(1'b1, 8'h24, 32'h0000ab00, 4'h2);
      rd(8'h24, 32'h5000ab34);
      apb(1'b1, 8'h28, 32'hffff0100, 4'hf);
      apb(1'b1, 8'h28, 32'h000000cc, 4'h1);
      rd(8'h28, 32'h000001cc);
      $display("test byte lanes done");
      apb(1'b1, 8'h30, 32'hffffffff, 4'hf);
      chk("pslverr", 32'h1, {31'h0, rerr});
      rd(8'h30, 32'h00000000);
      chk("pslverr", 32'h1, {31'h0, rerr});
      rd(8'h24, 32'h5000ab34);
      $display("test unmapped done");
      apb(1'b1, 8'h24, 32'h30001000, 4'hf);
      apb(1'b1, 8'h28, 32'h00000400, 4'hf);
      conv(14'h0400, 5'b00000);
      conv(14'h0401, 5'b10101);
      rd(8'h2c, 32'h00000411);
      conv(14'h03fe, 5'b10101);
      conv(14'h03fd, 5'b00101);
      rd(8'h2c, 32'h00000011);
      apb(1'b1, 8'h2c, 32'h00000010, 4'h1);
      conv(14'h0100, 5'b00000);
      conv(14'h00ff, 5'b01011);
      rd(8'h2c, 32'h00000821);
      apb(1'b1, 8'h2c, 32'h00000020, 4'h1);
      rd(8'h2c, 32'h00000821);
      conv(14'h0102, 5'b01011);
      conv(14'h0103, 5'b00011);
      rd(8'h2c, 32'h00000021);
      apb(1'b1, 8'h2c, 32'h00000020, 4'h1);
      rd(8'h2c, 32'h00000000);
      $display("test alarms done");
      stop_test;
   end
endmodule // input_alarm_threshold_regs_test
`default_nettype wire
